// ==== src/rnc_map.vh ====
// Constants of the ring node controller: channel numbers, commands,
// register bit positions, reset values and timing counts.
// Assumes a 20 MHz core clock; included by every design file.
`ifndef RNC_MAP_VH
`define RNC_MAP_VH

// Channel numbers carried in the first payload byte
`define RNC_CH_NODE        8'h00
`define RNC_CH_I2C_HI      4'h1
`define RNC_CH_BCAST       8'h20
`define RNC_CH_PIO_HI      4'h3
`define RNC_CH_PIO_LAST    4'h3
`define RNC_CH_MEM         8'h40
`define RNC_CH_TRIG        8'h50
`define RNC_CH_JTAG        8'h60
`define RNC_CH_ALARM       8'hFE
`define RNC_ALARM_TRN      8'h00

// Node controller command codes
`define RNC_CMD_WR_GEN     8'h00
`define RNC_CMD_WR_ALARM   8'h01
`define RNC_CMD_WR_STATUS  8'h02
`define RNC_CMD_RD_GEN     8'h10
`define RNC_CMD_RD_ALARM   8'h11
`define RNC_CMD_RD_STATUS  8'h12

// general_control bits
`define RNC_GC_EXT_RESET   5
`define RNC_GC_CLR_ERR     6
`define RNC_GC_COLD_RESET  7

// alarm_retry_control fields
`define RNC_AR_EN_MSB      3
`define RNC_AR_EN_LSB      0
`define RNC_AR_RETRY_MSB   5
`define RNC_AR_RETRY_LSB   4
`define RNC_AR_EN_RESET    4'h0
`define RNC_AR_RETRY_RESET 2'h3

// Retry counts per field code
`define RNC_RETRY_0        3'h0
`define RNC_RETRY_1        3'h1
`define RNC_RETRY_2        3'h2
`define RNC_RETRY_3        3'h4

// Status register bits
`define RNC_ST_INV_CMD     0
`define RNC_ST_CH_ERR      1
`define RNC_ST_ALARM       2
`define RNC_ST_GLOBAL      7

// Timing in 50 ns core cycles, sized to the timer width
`define RNC_TMR_W          15
`define RNC_EXT_RESET_CYC  15'h00C8
`define RNC_ALARM_TMO_CYC  15'h4E20

`endif

// ==== src/rnc_timer.v ====
// One-shot cycle timer: busy for COUNT cycles after start, then done.
// Assumes start and abort are single-cycle strobes in the core domain.
`timescale 1ns/100ps
`default_nettype none
`include "rnc_map.vh"
module rnc_timer #(
  parameter [`RNC_TMR_W-1:0] COUNT = 15'h0001
) (
  input  wire                  clk_in,
  input  wire                  rst_n_in,
  input  wire                  start_in,
  input  wire                  abort_in,
  output reg                   busy_out,
  output reg                   done_out
);
  reg [`RNC_TMR_W-1:0] cnt_reg;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg  <= 15'h0000;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        cnt_reg  <= COUNT;
        busy_out <= 1'b1;
      end else if (abort_in) begin
        busy_out <= 1'b0;
      end else if (busy_out) begin
        cnt_reg <= cnt_reg - 15'h0001;
        if (cnt_reg == 15'h0001) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/rnc_alarm.v ====
// Alarm packet sender: picks an enabled active alarm, emits the
// three-byte interrupt packet and retransmits on timeout.
// Assumes a timeout timer outside and a clear strobe from the ring side.
`timescale 1ns/100ps
`default_nettype none
`include "rnc_map.vh"
module rnc_alarm (
  input  wire       clk_in,
  input  wire       rst_n_in,
  input  wire [3:0] alarm_n_in,
  input  wire [3:0] enable_in,
  input  wire [1:0] retry_limit_in,
  input  wire       clear_in,
  input  wire       timeout_in,
  output reg        timer_start_out,
  output reg  [3:0] en_clear_out,
  output reg        tx_valid_out,
  output reg  [7:0] tx_data_out,
  output reg        tx_last_out
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SEND = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  reg [2:0] state_reg;
  reg [1:0] byte_reg;
  reg [2:0] left_reg;
  reg [7:0] num_reg;
  reg [7:0] num_next;
  reg [3:0] pick_next;
  reg [2:0] limit_next;
  wire [3:0] firing = ~alarm_n_in & enable_in;

  always @* begin
    num_next  = 8'h00;
    pick_next = 4'h0;
    if (firing[0]) begin
      num_next  = 8'h01;
      pick_next = 4'h1;
    end else if (firing[1]) begin
      num_next  = 8'h02;
      pick_next = 4'h2;
    end else if (firing[2]) begin
      num_next  = 8'h03;
      pick_next = 4'h4;
    end else if (firing[3]) begin
      num_next  = 8'h04;
      pick_next = 4'h8;
    end
    case (retry_limit_in)
      2'h0:    limit_next = `RNC_RETRY_0;
      2'h1:    limit_next = `RNC_RETRY_1;
      2'h2:    limit_next = `RNC_RETRY_2;
      default: limit_next = `RNC_RETRY_3;
    endcase
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg       <= ST_IDLE;
      byte_reg        <= 2'h0;
      left_reg        <= 3'h0;
      num_reg         <= 8'h00;
      timer_start_out <= 1'b0;
      en_clear_out    <= 4'h0;
      tx_valid_out    <= 1'b0;
      tx_data_out     <= 8'h00;
      tx_last_out     <= 1'b0;
    end else begin
      timer_start_out <= 1'b0;
      en_clear_out    <= 4'h0;
      tx_valid_out    <= 1'b0;
      tx_last_out     <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (pick_next != 4'h0) begin
            num_reg      <= num_next;
            left_reg     <= limit_next;
            byte_reg     <= 2'h0;
            en_clear_out <= pick_next;
            state_reg    <= ST_SEND;
          end
        end
        ST_SEND: begin
          tx_valid_out <= 1'b1;
          byte_reg     <= byte_reg + 2'h1;
          case (byte_reg)
            2'h0:    tx_data_out <= `RNC_CH_ALARM;
            2'h1:    tx_data_out <= `RNC_ALARM_TRN;
            default: begin
              tx_data_out     <= num_reg;
              tx_last_out     <= 1'b1;
              timer_start_out <= 1'b1;
              state_reg       <= ST_WAIT;
            end
          endcase
        end
        ST_WAIT: begin
          if (clear_in) begin
            state_reg <= ST_IDLE;
          end else if (timeout_in) begin
            if (left_reg != 3'h0) begin
              left_reg  <= left_reg - 3'h1;
              byte_reg  <= 2'h0;
              state_reg <= ST_SEND;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== src/rnc_node_ctrl.v ====
// Node controller channel: dispatches ring messages by channel number,
// holds the control registers reached as channel 0, sends alarm packets.
// Assumes a byte stream of CRC-checked messages, one byte per valid.
`timescale 1ns/100ps
`default_nettype none
`include "rnc_map.vh"
module rnc_node_ctrl #(
  parameter [`RNC_TMR_W-1:0] ALARM_TIMEOUT_CYCLES = `RNC_ALARM_TMO_CYC
) (
  input  wire        CORE_CLK_IN,
  input  wire        NRST_IN,
  input  wire        MSG_VALID_IN,
  input  wire [7:0]  MSG_DATA_IN,
  input  wire        MSG_LAST_IN,
  input  wire        CH_ERROR_IN,
  input  wire [3:0]  ALARM_INPUTS_N_IN,
  input  wire        ALARM_CLEAR_IN,
  output wire        CH_VALID_OUT,
  output wire [7:0]  CH_DATA_OUT,
  output wire        CH_LAST_OUT,
  output wire [15:0] I2C_SEL_OUT,
  output wire        I2C_POSTED_OUT,
  output wire [3:0]  PIO_SEL_OUT,
  output wire        MEM_SEL_OUT,
  output wire        TRIG_SEL_OUT,
  output wire        JTAG_SEL_OUT,
  output wire        REPLY_VALID_OUT,
  output wire [7:0]  REPLY_DATA_OUT,
  output wire        REPLY_LAST_OUT,
  output wire        ALARM_VALID_OUT,
  output wire [7:0]  ALARM_DATA_OUT,
  output wire        ALARM_LAST_OUT,
  output wire        EXTERNAL_RESET_OUTPUT_N_OUT,
  output wire        CHANNELS_COLD_RESET_OUT,
  output wire        CLEAR_ERROR_FLAGS_OUT
);
  localparam [`RNC_TMR_W-1:0] EXT_RESET_CYCLES = `RNC_EXT_RESET_CYC;

  // Message tracking
  reg  [1:0]  idx_reg;
  reg         node_reg;
  reg  [15:0] i2c_sel_reg;
  reg         bcast_reg;
  reg  [3:0]  pio_sel_reg;
  reg         mem_sel_reg;
  reg         trig_sel_reg;
  reg         jtag_sel_reg;
  reg         ch_valid_reg;
  reg  [7:0]  ch_data_reg;
  reg         ch_last_reg;
  reg  [7:0]  trn_reg;
  reg  [7:0]  cmd_reg;
  reg  [7:0]  wdata_reg;
  reg         got_cmd_reg;
  reg         got_data_reg;
  reg         exec_reg;

  // Registers and flags
  reg  [3:0]  alarm_en_reg;
  reg  [1:0]  retry_reg;
  reg         inv_cmd_reg;
  reg         ch_err_reg;
  reg         clr_err_reg;
  reg         cold_rst_reg;
  reg         ext_rst_n_reg;

  // Reply serializer
  reg  [23:0] reply_sh_reg;
  reg  [1:0]  reply_left_reg;
  reg         reply_valid_reg;
  reg  [7:0]  reply_data_reg;
  reg         reply_last_reg;

  // Decode of the channel byte
  reg  [15:0] i2c_sel_next;
  reg  [3:0]  pio_sel_next;
  reg         node_next;
  reg         bcast_next;
  reg         mem_next;
  reg         trig_next;
  reg         jtag_next;
  reg         chan_bad_next;

  // Command execution
  reg         wr_gen;
  reg         wr_alarm;
  reg         rd_any;
  reg         cmd_bad;
  reg  [7:0]  rdata;

  wire        first_byte = MSG_VALID_IN && (idx_reg == 2'h0);
  wire        body_byte  = MSG_VALID_IN && (idx_reg != 2'h0);
  wire        to_channel = (i2c_sel_reg != 16'h0000) ||
                           (pio_sel_reg != 4'h0) || mem_sel_reg ||
                           trig_sel_reg || jtag_sel_reg;
  wire        pulse_busy;
  wire        tmo_done;
  wire        tmo_start;
  wire [3:0]  en_clear;
  wire        alarm_any = (ALARM_INPUTS_N_IN != 4'hF);
  wire        ext_start = wr_gen && wdata_reg[`RNC_GC_EXT_RESET];
  wire        err_clear = wr_gen && wdata_reg[`RNC_GC_CLR_ERR];

  always @* begin
    i2c_sel_next = 16'h0000;
    pio_sel_next = 4'h0;
    node_next    = (MSG_DATA_IN == `RNC_CH_NODE);
    bcast_next   = (MSG_DATA_IN == `RNC_CH_BCAST);
    mem_next     = (MSG_DATA_IN == `RNC_CH_MEM);
    trig_next    = (MSG_DATA_IN == `RNC_CH_TRIG);
    jtag_next    = (MSG_DATA_IN == `RNC_CH_JTAG);
    if (MSG_DATA_IN[7:4] == `RNC_CH_I2C_HI) begin
      i2c_sel_next[MSG_DATA_IN[3:0]] = 1'b1;
    end
    if (bcast_next) begin
      i2c_sel_next = 16'hFFFF;
    end
    if ((MSG_DATA_IN[7:4] == `RNC_CH_PIO_HI) &&
        (MSG_DATA_IN[3:0] <= `RNC_CH_PIO_LAST)) begin
      pio_sel_next[MSG_DATA_IN[1:0]] = 1'b1;
    end
    chan_bad_next = !node_next && (i2c_sel_next == 16'h0000) &&
                    (pio_sel_next == 4'h0) && !mem_next &&
                    !trig_next && !jtag_next;
  end

  always @* begin
    wr_gen   = 1'b0;
    wr_alarm = 1'b0;
    rd_any   = 1'b0;
    cmd_bad  = 1'b0;
    rdata    = 8'h00;
    if (exec_reg) begin
      case (cmd_reg)
        `RNC_CMD_WR_GEN: begin
          wr_gen  = got_data_reg;
          cmd_bad = !got_data_reg;
        end
        `RNC_CMD_WR_ALARM: begin
          wr_alarm = got_data_reg;
          cmd_bad  = !got_data_reg;
        end
        `RNC_CMD_WR_STATUS: cmd_bad = !got_data_reg;
        `RNC_CMD_RD_GEN: begin
          rd_any = 1'b1;
          rdata[`RNC_GC_EXT_RESET] = !ext_rst_n_reg;
        end
        `RNC_CMD_RD_ALARM: begin
          rd_any = 1'b1;
          rdata[`RNC_AR_EN_MSB:`RNC_AR_EN_LSB]       = alarm_en_reg;
          rdata[`RNC_AR_RETRY_MSB:`RNC_AR_RETRY_LSB] = retry_reg;
        end
        `RNC_CMD_RD_STATUS: begin
          rd_any = 1'b1;
          rdata[`RNC_ST_INV_CMD] = inv_cmd_reg;
          rdata[`RNC_ST_CH_ERR]  = ch_err_reg;
          rdata[`RNC_ST_ALARM]   = alarm_any;
          rdata[`RNC_ST_GLOBAL]  = inv_cmd_reg | ch_err_reg;
        end
        default: cmd_bad = 1'b1;
      endcase
      if (!got_cmd_reg) begin
        cmd_bad = 1'b1;
        rd_any  = 1'b0;
      end
    end
  end

  // Message intake and channel forwarding
  always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      idx_reg      <= 2'h0;
      node_reg     <= 1'b0;
      i2c_sel_reg  <= 16'h0000;
      bcast_reg    <= 1'b0;
      pio_sel_reg  <= 4'h0;
      mem_sel_reg  <= 1'b0;
      trig_sel_reg <= 1'b0;
      jtag_sel_reg <= 1'b0;
      ch_valid_reg <= 1'b0;
      ch_data_reg  <= 8'h00;
      ch_last_reg  <= 1'b0;
      trn_reg      <= 8'h00;
      cmd_reg      <= 8'h00;
      wdata_reg    <= 8'h00;
      got_cmd_reg  <= 1'b0;
      got_data_reg <= 1'b0;
      exec_reg     <= 1'b0;
    end else begin
      ch_valid_reg <= 1'b0;
      ch_last_reg  <= 1'b0;
      exec_reg     <= 1'b0;
      if (MSG_VALID_IN) begin
        if (MSG_LAST_IN) begin
          idx_reg <= 2'h0;
        end else if (idx_reg != 2'h3) begin
          idx_reg <= idx_reg + 2'h1;
        end
      end
      if (first_byte && !MSG_LAST_IN) begin
        node_reg     <= node_next;
        i2c_sel_reg  <= i2c_sel_next;
        bcast_reg    <= bcast_next;
        pio_sel_reg  <= pio_sel_next;
        mem_sel_reg  <= mem_next;
        trig_sel_reg <= trig_next;
        jtag_sel_reg <= jtag_next;
        got_cmd_reg  <= 1'b0;
        got_data_reg <= 1'b0;
      end else if (ch_last_reg || exec_reg) begin
        node_reg     <= 1'b0;
        i2c_sel_reg  <= 16'h0000;
        bcast_reg    <= 1'b0;
        pio_sel_reg  <= 4'h0;
        mem_sel_reg  <= 1'b0;
        trig_sel_reg <= 1'b0;
        jtag_sel_reg <= 1'b0;
      end
      if (body_byte && to_channel) begin
        ch_valid_reg <= 1'b1;
        ch_data_reg  <= MSG_DATA_IN;
        ch_last_reg  <= MSG_LAST_IN;
      end
      if (body_byte && node_reg) begin
        case (idx_reg)
          2'h1: trn_reg <= MSG_DATA_IN;
          2'h2: begin
            cmd_reg     <= MSG_DATA_IN;
            got_cmd_reg <= 1'b1;
          end
          default: begin
            // Trailing bytes overwrite; last data byte wins
            wdata_reg    <= MSG_DATA_IN;
            got_data_reg <= 1'b1;
          end
        endcase
        exec_reg <= MSG_LAST_IN;
      end
    end
  end

  // Control registers, error flags and strobes
  always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      alarm_en_reg  <= `RNC_AR_EN_RESET;
      retry_reg     <= `RNC_AR_RETRY_RESET;
      inv_cmd_reg   <= 1'b0;
      ch_err_reg    <= 1'b0;
      clr_err_reg   <= 1'b0;
      cold_rst_reg  <= 1'b0;
      ext_rst_n_reg <= 1'b1;
    end else begin
      alarm_en_reg <= (alarm_en_reg & ~en_clear) |
                      (wr_alarm ? wdata_reg[`RNC_AR_EN_MSB:`RNC_AR_EN_LSB]
                                : 4'h0);
      if (wr_alarm) begin
        retry_reg <= wdata_reg[`RNC_AR_RETRY_MSB:`RNC_AR_RETRY_LSB];
      end
      inv_cmd_reg <= cmd_bad || (first_byte && chan_bad_next) ||
                     (inv_cmd_reg && !err_clear);
      ch_err_reg  <= CH_ERROR_IN || (ch_err_reg && !err_clear);
      clr_err_reg <= err_clear;
      cold_rst_reg <= wr_gen && wdata_reg[`RNC_GC_COLD_RESET];
      // low while timer runs
      // Trails busy by one cycle, so low for exactly the count
      ext_rst_n_reg <= !pulse_busy;
    end
  end

  always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      reply_sh_reg    <= 24'h000000;
      reply_left_reg  <= 2'h0;
      reply_valid_reg <= 1'b0;
      reply_data_reg  <= 8'h00;
      reply_last_reg  <= 1'b0;
    end else begin
      reply_valid_reg <= 1'b0;
      reply_last_reg  <= 1'b0;
      if (rd_any && (reply_left_reg == 2'h0)) begin
        reply_sh_reg   <= {`RNC_CH_NODE, trn_reg, rdata};
        reply_left_reg <= 2'h3;
      end else if (reply_left_reg != 2'h0) begin
        reply_valid_reg <= 1'b1;
        reply_data_reg  <= reply_sh_reg[23:16];
        reply_last_reg  <= (reply_left_reg == 2'h1);
        reply_sh_reg    <= {reply_sh_reg[15:0], 8'h00};
        reply_left_reg  <= reply_left_reg - 2'h1;
      end
    end
  end

  // Pulse length counts from the write strobe
  rnc_timer #(
    .COUNT (EXT_RESET_CYCLES)
  ) u_ext_pulse (
    .clk_in   (CORE_CLK_IN),
    .rst_n_in (NRST_IN),
    .start_in (ext_start),
    .abort_in (1'b0),
    .busy_out (pulse_busy),
    .done_out ()
  );

  rnc_timer #(
    .COUNT (ALARM_TIMEOUT_CYCLES)
  ) u_alarm_tmo (
    .clk_in   (CORE_CLK_IN),
    .rst_n_in (NRST_IN),
    .start_in (tmo_start),
    .abort_in (ALARM_CLEAR_IN),
    .busy_out (),
    .done_out (tmo_done)
  );

  rnc_alarm u_alarm (
    .clk_in          (CORE_CLK_IN),
    .rst_n_in        (NRST_IN),
    .alarm_n_in      (ALARM_INPUTS_N_IN),
    .enable_in       (alarm_en_reg),
    .retry_limit_in  (retry_reg),
    .clear_in        (ALARM_CLEAR_IN),
    .timeout_in      (tmo_done),
    .timer_start_out (tmo_start),
    .en_clear_out    (en_clear),
    .tx_valid_out    (ALARM_VALID_OUT),
    .tx_data_out     (ALARM_DATA_OUT),
    .tx_last_out     (ALARM_LAST_OUT)
  );

  assign CH_VALID_OUT                = ch_valid_reg;
  assign CH_DATA_OUT                 = ch_data_reg;
  assign CH_LAST_OUT                 = ch_last_reg;
  assign I2C_SEL_OUT                 = i2c_sel_reg;
  assign I2C_POSTED_OUT              = bcast_reg;
  assign PIO_SEL_OUT                 = pio_sel_reg;
  assign MEM_SEL_OUT                 = mem_sel_reg;
  assign TRIG_SEL_OUT                = trig_sel_reg;
  assign JTAG_SEL_OUT                = jtag_sel_reg;
  assign REPLY_VALID_OUT             = reply_valid_reg;
  assign REPLY_DATA_OUT              = reply_data_reg;
  assign REPLY_LAST_OUT              = reply_last_reg;
  assign EXTERNAL_RESET_OUTPUT_N_OUT = ext_rst_n_reg;
  assign CHANNELS_COLD_RESET_OUT     = cold_rst_reg;
  assign CLEAR_ERROR_FLAGS_OUT       = clr_err_reg;
endmodule
`default_nettype wire

// ==== tb/rnc_properties.sv ====
// Checker on node controller ports: dispatch, frames, pulse lengths.
// Assumes whole messages on the input; bound to the design below.
`timescale 1ns/100ps
`default_nettype none
module rnc_properties #(
  parameter [14:0] ALARM_TIMEOUT_CYCLES = 15'h0032
) (
  input wire logic        CORE_CLK_IN,
  input wire logic        NRST_IN,
  input wire logic        MSG_VALID_IN,
  input wire logic [7:0]  MSG_DATA_IN,
  input wire logic        MSG_LAST_IN,
  input wire logic        CH_VALID_OUT,
  input wire logic [7:0]  CH_DATA_OUT,
  input wire logic        CH_LAST_OUT,
  input wire logic [15:0] I2C_SEL_OUT,
  input wire logic        I2C_POSTED_OUT,
  input wire logic [3:0]  PIO_SEL_OUT,
  input wire logic        REPLY_VALID_OUT,
  input wire logic [7:0]  REPLY_DATA_OUT,
  input wire logic        REPLY_LAST_OUT,
  input wire logic        ALARM_VALID_OUT,
  input wire logic [7:0]  ALARM_DATA_OUT,
  input wire logic        ALARM_LAST_OUT,
  input wire logic        EXTERNAL_RESET_OUTPUT_N_OUT,
  input wire logic        CHANNELS_COLD_RESET_OUT
);
  logic       first_q;
  logic [8:0] low_cnt;
  wire        sof = MSG_VALID_IN && first_q && !MSG_LAST_IN;
  wire        rsv = !(MSG_DATA_IN inside {8'h00, 8'h20, 8'h40, 8'h50,
                      8'h60, [8'h10:8'h1F], [8'h30:8'h33]});
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      first_q <= 1'b1;
      low_cnt <= 9'h000;
    end else begin
      if (MSG_VALID_IN) first_q <= MSG_LAST_IN;
      low_cnt <= EXTERNAL_RESET_OUTPUT_N_OUT ? 9'h000 : low_cnt + 9'h001;
    end
  end
  a_i2c_onehot: assert property (sof && MSG_DATA_IN[7:4] == 4'h1 |=>
    I2C_SEL_OUT == 16'h0001 << $past(MSG_DATA_IN[3:0]) && !I2C_POSTED_OUT)
    else $error("i2c select wrong");
  a_bcast_all: assert property (sof && MSG_DATA_IN == 8'h20 |=>
    I2C_SEL_OUT == 16'hFFFF && I2C_POSTED_OUT) else $error("bcast wrong");
  a_pio_onehot: assert property (sof && MSG_DATA_IN[7:2] == 6'h0C |=>
    PIO_SEL_OUT == 4'h1 << $past(MSG_DATA_IN[1:0])) else $error("pio wrong");
  a_reserved_none: assert property (sof && rsv |=>
    I2C_SEL_OUT == 16'h0000 && PIO_SEL_OUT == 4'h0) else $error("reserved");
  a_fwd_byte: assert property (CH_VALID_OUT |->
    $past(MSG_VALID_IN) && CH_DATA_OUT == $past(MSG_DATA_IN))
    else $error("forward wrong");
  a_fwd_last: assert property (CH_VALID_OUT || CH_LAST_OUT |->
    CH_VALID_OUT && CH_LAST_OUT == $past(MSG_LAST_IN))
    else $error("forward last wrong");
  a_reset_len: assert property ($rose(EXTERNAL_RESET_OUTPUT_N_OUT) |->
    low_cnt == 9'h0C8) else $error("reset pulse length");
  a_alarm_frame: assert property ($rose(ALARM_VALID_OUT) |->
    ALARM_DATA_OUT == 8'hFE ##1 ALARM_VALID_OUT && ALARM_DATA_OUT == 8'h00
    ##1 ALARM_LAST_OUT && ALARM_DATA_OUT inside {[8'h01:8'h04]})
    else $error("alarm frame");
  a_reply_frame: assert property ($rose(REPLY_VALID_OUT) |->
    REPLY_DATA_OUT == 8'h00 ##2 REPLY_VALID_OUT && REPLY_LAST_OUT)
    else $error("reply frame");
  a_posted_quiet: assert property (I2C_POSTED_OUT |->
    !REPLY_VALID_OUT) else $error("posted reply");
  a_cold_pulse: assert property (CHANNELS_COLD_RESET_OUT |=>
    !CHANNELS_COLD_RESET_OUT) else $error("cold pulse long");
endmodule
bind rnc_node_ctrl rnc_properties #(
  .ALARM_TIMEOUT_CYCLES(ALARM_TIMEOUT_CYCLES)
) u_props (
  .CORE_CLK_IN, .NRST_IN, .MSG_VALID_IN, .MSG_DATA_IN, .MSG_LAST_IN,
  .CH_VALID_OUT, .CH_DATA_OUT, .CH_LAST_OUT, .I2C_SEL_OUT, .I2C_POSTED_OUT,
  .PIO_SEL_OUT,
  .REPLY_VALID_OUT, .REPLY_DATA_OUT, .REPLY_LAST_OUT, .ALARM_VALID_OUT,
  .ALARM_DATA_OUT, .ALARM_LAST_OUT, .EXTERNAL_RESET_OUTPUT_N_OUT,
  .CHANNELS_COLD_RESET_OUT
);
`default_nettype wire

// ==== tb/rnc_ring_model.sv ====
// Ring master stand-in: sends messages, collects replies and alarms.
// Assumes send is entered just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module rnc_ring_model (
  input  wire logic       clk_in,
  input  wire logic       clr_en_in,
  input  wire logic       slow_in,
  input  wire logic       rep_valid_in,
  input  wire logic [7:0] rep_data_in,
  input  wire logic       al_valid_in,
  input  wire logic [7:0] al_data_in,
  input  wire logic       al_last_in,
  output logic            msg_valid_out,
  output logic [7:0]      msg_data_out,
  output logic            msg_last_out,
  output logic            al_clear_out
);
  logic [23:0] rep_pkt = 24'h000000;
  logic [23:0] al_pkt = 24'h000000;
  int          al_cnt = 0;
  initial begin
    msg_valid_out = 1'b0;
    msg_data_out = 8'h00;
    msg_last_out = 1'b0;
    al_clear_out = 1'b0;
  end
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      msg_valid_out = 1'b1;
      msg_data_out = q[i];
      msg_last_out = i == q.size() - 1;
      @(posedge clk_in) #1;
    end
    msg_valid_out = 1'b0;
    msg_last_out = 1'b0;
    // Idle bus shows no stale byte
    msg_data_out = ~msg_data_out;
    @(posedge clk_in) #1;
  endtask
  always @(posedge clk_in) begin
    if (rep_valid_in) rep_pkt <= {rep_pkt[15:0], rep_data_in};
    if (al_valid_in) al_pkt <= {al_pkt[15:0], al_data_in};
    if (al_valid_in && al_last_in) al_cnt <= al_cnt + 1;
  end
  always begin
    @(posedge clk_in iff (al_valid_in && al_last_in && clr_en_in));
    repeat (slow_in ? 30 : 2) @(posedge clk_in);
    #1 al_clear_out = 1'b1;
    @(posedge clk_in) #1 al_clear_out = 1'b0;
  end
endmodule
`default_nettype wire

// ==== tb/rnc_node_ctrl_bench.sv ====
// Bench: dispatch table, node registers, pulses and alarm retries.
// Assumes the ring model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module rnc_node_ctrl_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ch_err = 1'b0;
  logic [3:0]  alarm_n = 4'hF;
  logic        clr_en = 1'b0;
  wire         m_vld, m_lst, a_clr, r_vld, r_lst, a_vld, a_lst;
  wire  [7:0]  m_dat, r_dat, a_dat, c_dat;
  wire         c_vld, c_lst, posted, mem, trig, jtag, ext_n, cold, clear_error_flags;
  wire  [15:0] i2c;
  wire  [3:0]  pio;
  int          err_total = 0;
  int          checks_done = 0;
  int          low_len = 0;
  int          n_fwd = 0;
  int          n0;
  int          pk [4] = '{1, 2, 3, 5};
  logic [22:0] sel_acc = 23'h0;
  logic        post_acc = 1'b0;
  logic        clear_error_flags_seen = 1'b0;
  logic        cold_seen = 1'b0;
  logic [30:0] rows [18] = '{{8'h10, 23'h80}, {8'h13, 23'h400},
    {8'h1F, 23'h400000}, {8'h20, 23'h7FFF80}, {8'h30, 23'h8},
    {8'h33, 23'h40}, {8'h40, 23'h4}, {8'h50, 23'h2}, {8'h60, 23'h1},
    {8'h01, 23'h0}, {8'h0F, 23'h0}, {8'h21, 23'h0}, {8'h34, 23'h0},
    {8'h41, 23'h0}, {8'h51, 23'h0}, {8'h5F, 23'h0}, {8'h61, 23'h0},
    {8'hFF, 23'h0}};
  rnc_node_ctrl #(.ALARM_TIMEOUT_CYCLES(15'h0032)) u_dut (
    .CORE_CLK_IN(clk), .NRST_IN(rst_n), .MSG_VALID_IN(m_vld),
    .MSG_DATA_IN(m_dat), .MSG_LAST_IN(m_lst), .CH_ERROR_IN(ch_err),
    .ALARM_INPUTS_N_IN(alarm_n), .ALARM_CLEAR_IN(a_clr),
    .CH_VALID_OUT(c_vld), .CH_DATA_OUT(c_dat), .CH_LAST_OUT(c_lst),
    .I2C_SEL_OUT(i2c), .I2C_POSTED_OUT(posted), .PIO_SEL_OUT(pio),
    .MEM_SEL_OUT(mem), .TRIG_SEL_OUT(trig), .JTAG_SEL_OUT(jtag),
    .REPLY_VALID_OUT(r_vld), .REPLY_DATA_OUT(r_dat), .REPLY_LAST_OUT(r_lst),
    .ALARM_VALID_OUT(a_vld), .ALARM_DATA_OUT(a_dat), .ALARM_LAST_OUT(a_lst),
    .EXTERNAL_RESET_OUTPUT_N_OUT(ext_n), .CHANNELS_COLD_RESET_OUT(cold),
    .CLEAR_ERROR_FLAGS_OUT(clear_error_flags));
  rnc_ring_model u_ring (.clk_in(clk), .clr_en_in(clr_en), .slow_in(1'b1),
    .rep_valid_in(r_vld), .rep_data_in(r_dat), .al_valid_in(a_vld),
    .al_data_in(a_dat), .al_last_in(a_lst), .msg_valid_out(m_vld),
    .msg_data_out(m_dat), .msg_last_out(m_lst), .al_clear_out(a_clr));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    sel_acc <= sel_acc | {i2c, pio, mem, trig, jtag};
    post_acc <= post_acc | posted;
    n_fwd <= n_fwd + int'(c_vld);
    clear_error_flags_seen <= clear_error_flags_seen | clear_error_flags;
    cold_seen <= cold_seen | cold;
    low_len <= low_len + int'(!ext_n);
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] cmd, d);
    u_ring.send('{8'h00, 8'h5C, cmd, d});
    tick(3);
  endtask
  task automatic rd(input logic [7:0] cmd, exp, input string what);
    u_ring.rep_pkt = 24'hFFFFFF;
    u_ring.send('{8'h00, 8'h3C, cmd});
    for (int i = 0; i < 12 && u_ring.rep_pkt[7:0] !== exp; i++) tick(1);
    tick(2);
    check(what, u_ring.rep_pkt, {16'h003C, exp});
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    tick(20);
    rst_n = 1'b1;
    rd(8'h11, 8'h30, "alarm ctrl reset");
    rd(8'h10, 8'h00, "general ctrl reset");
    foreach (rows[k]) begin
      sel_acc = 23'h0;
      post_acc = 1'b0;
      n_fwd = 0;
      u_ring.send('{rows[k][30:23], 8'hA5, 8'h5A});
      tick(2);
      check("selects", sel_acc, rows[k][22:0]);
      check("posted", post_acc, rows[k][30:23] == 8'h20);
      check("forwarded", n_fwd, rows[k][22:0] != 0 ? 2 : 0);
      rd(8'h12, rows[k][22:0] != 0 ? 8'h00 : 8'h81, "status");
      clear_error_flags_seen = 1'b0;
      wr(8'h00, 8'h40);
      check("clear pulse", clear_error_flags_seen, 1'b1);
    end
    for (int c = 0; c < 4; c++) begin
      n0 = u_ring.al_cnt;
      wr(8'h01, {2'h0, c[1:0], 4'h1 << c});
      wr(8'h01, {2'h0, c[1:0], 4'h0});
      rd(8'h11, {2'h0, c[1:0], 4'h1 << c}, "enable kept");
      tick(20);
      check("no alarm high", u_ring.al_cnt, n0);
      alarm_n[c] = 1'b0;
      tick(400);
      check("alarm sends", u_ring.al_cnt - n0, pk[c]);
      check("alarm pkt", u_ring.al_pkt, {16'hFE00, c[7:0] + 8'h01});
      rd(8'h11, {2'h0, c[1:0], 4'h0}, "enable auto clear");
      rd(8'h12, 8'h04, "alarm status");
      alarm_n = 4'hF;
    end
    clr_en = 1'b1;
    n0 = u_ring.al_cnt;
    wr(8'h01, 8'h32);
    alarm_n = 4'hD;
    tick(400);
    check("cleared alarm", u_ring.al_cnt - n0, 1);
    alarm_n = 4'hF;
    low_len = 0;
    wr(8'h00, 8'h20);
    rd(8'h10, 8'h20, "reset bit busy");
    tick(250);
    check("reset low", low_len, 200);
    rd(8'h10, 8'h00, "reset bit idle");
    wr(8'h01, 8'h10);
    cold_seen = 1'b0;
    wr(8'h00, 8'h80);
    check("cold pulse", cold_seen, 1'b1);
    rd(8'h11, 8'h10, "node kept");
    ch_err = 1'b1;
    tick(1);
    ch_err = 1'b0;
    wr(8'h02, 8'hFF);
    rd(8'h12, 8'h82, "channel error");
    u_ring.send('{8'h00, 8'h3C, 8'h05, 8'h01});
    rd(8'h12, 8'h83, "bad command");
    wr(8'h00, 8'h40);
    rd(8'h12, 8'h00, "errors cleared");
    wr(8'h01, 8'h05);
    rst_n = 1'b0;
    tick(20);
    rst_n = 1'b1;
    rd(8'h11, 8'h30, "alarm ctrl rereset");
    tally_and_finish();
  end
endmodule
`default_nettype wire
